/* File: pplb_pin_model.sv */
// board-side model of the port pins: buffers, pull-ups and outside drivers.
// assumes the bank's pin_oe, pin_out and pullup_en are registered on pclk.
`timescale 1ns/1ps

module pplb_pin_model
	import pplb_pkg::*;
(
	input  wire logic                       pclk,
	input  wire logic [PPLB_NSLOT-1:0][7:0] pin_out,
	input  wire logic [PPLB_NSLOT-1:0][7:0] pin_oe,
	input  wire logic [PPLB_NSLOT-1:0][7:0] pullup_en,
	input  wire logic [PPLB_NSLOT-1:0][7:0] ext_drive,
	input  wire logic [PPLB_NSLOT-1:0][7:0] ext_en,
	output wire logic [PPLB_NSLOT-1:0][7:0] pin_in
);
	logic [PPLB_NSLOT-1:0][7:0] float_v = '0;
	wire  [PPLB_NSLOT-1:0][7:0] idle    = ~pin_oe & ~ext_en;

	// an undriven pin toggles so a missing pull-up never reads as a match
	always_ff @(posedge pclk) begin
		float_v <= ~float_v;
	end

	assign pin_in = (pin_out & pin_oe) | (ext_drive & ext_en & ~pin_oe)
		| (idle & pullup_en) | (idle & ~pullup_en & float_v);
endmodule

/* File: pplb_pkg.sv */
// constants for the port latch and pull-up bank: register indices,
// implemented-bit masks and reset values.
// assumes an apb master with 32-bit data; each byte register sits in the
// low byte of one aligned word at byte address four times its index.
package pplb_pkg;

	localparam int PPLB_NSLOT = 10;
	localparam int PPLB_AW    = 18;

	// printed offsets are register indices, byte address is four times them
	localparam logic [15:0] PPLB_IDX_PORT0  = 16'hff00;
	localparam logic [15:0] PPLB_IDX_PORT1  = 16'hff01;
	localparam logic [15:0] PPLB_IDX_PORT2  = 16'hff02;
	localparam logic [15:0] PPLB_IDX_PORT3  = 16'hff03;
	localparam logic [15:0] PPLB_IDX_PORT4  = 16'hff04;
	localparam logic [15:0] PPLB_IDX_PORT5  = 16'hff05;
	localparam logic [15:0] PPLB_IDX_PORT6  = 16'hff06;
	localparam logic [15:0] PPLB_IDX_PORT7  = 16'hff07;
	localparam logic [15:0] PPLB_IDX_PORT12 = 16'hff0c;
	localparam logic [15:0] PPLB_IDX_PORT13 = 16'hff0d;
	localparam logic [15:0] PPLB_IDX_PORT14 = 16'hff0e;
	localparam logic [15:0] PPLB_IDX_PULL0  = 16'hff30;
	localparam logic [15:0] PPLB_IDX_PULL1  = 16'hff31;
	localparam logic [15:0] PPLB_IDX_PULL3  = 16'hff33;
	localparam logic [15:0] PPLB_IDX_PULL4  = 16'hff34;
	localparam logic [15:0] PPLB_IDX_PULL5  = 16'hff35;
	localparam logic [15:0] PPLB_IDX_PULL6  = 16'hff36;
	localparam logic [15:0] PPLB_IDX_PULL7  = 16'hff37;
	localparam logic [15:0] PPLB_IDX_PULL12 = 16'hff3c;
	localparam logic [15:0] PPLB_IDX_PULL14 = 16'hff3e;
	localparam logic [15:0] PPLB_IDX_NONE   = 16'h0000;

	// slot order, lowest first: ports 0,1,3,4,5,6,7,12,13,14
	localparam logic [PPLB_NSLOT-1:0][15:0] PPLB_DATA_IDX = {
		PPLB_IDX_PORT14, PPLB_IDX_PORT13, PPLB_IDX_PORT12,
		PPLB_IDX_PORT7, PPLB_IDX_PORT6, PPLB_IDX_PORT5,
		PPLB_IDX_PORT4, PPLB_IDX_PORT3, PPLB_IDX_PORT1,
		PPLB_IDX_PORT0};
	localparam logic [PPLB_NSLOT-1:0][15:0] PPLB_PULL_IDX = {
		PPLB_IDX_PULL14, PPLB_IDX_NONE, PPLB_IDX_PULL12,
		PPLB_IDX_PULL7, PPLB_IDX_PULL6, PPLB_IDX_PULL5,
		PPLB_IDX_PULL4, PPLB_IDX_PULL3, PPLB_IDX_PULL1,
		PPLB_IDX_PULL0};
	// port 13 has no pull-select register
	localparam logic [PPLB_NSLOT-1:0] PPLB_PULL_VALID = 10'h2ff;

	localparam logic [PPLB_NSLOT-1:0][7:0] PPLB_DATA_MASK = {
		8'h3f, 8'h01, 8'h01, 8'hff, 8'hff,
		8'hff, 8'hff, 8'h0f, 8'hff, 8'h7f};
	localparam logic [PPLB_NSLOT-1:0][7:0] PPLB_PULL_MASK = {
		8'h3f, 8'h00, 8'h01, 8'hff, 8'hf0,
		8'hff, 8'hff, 8'h0f, 8'hff, 8'h7f};

	localparam logic [7:0]  PPLB_LATCH_RESET = 8'h00;
	localparam logic [7:0]  PPLB_PULL_RESET  = 8'h00;
	localparam logic [23:0] PPLB_RDATA_PAD   = 24'h00_0000;
	localparam logic [31:0] PPLB_RDATA_RESET = 32'h0000_0000;

endpackage

/* File: pplb_port_bank.sv */
// one port: output latch, pull-select register, buffer and pull-up enables.
// assumes writes arrive as one-cycle enables from the bus slave.
`timescale 1ns/1ps

module pplb_port_bank
	import pplb_pkg::*;
#(
	parameter logic [7:0] DATA_MASK = 8'hff,
	parameter logic [7:0] PULL_MASK = 8'hff
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       wr_data_en,
	input  wire logic       wr_pull_en,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] direction,
	input  wire logic [7:0] alt_out,
	input  wire logic [7:0] pin_in,
	output logic      [7:0] latch,
	output logic      [7:0] pull_sel,
	output wire logic [7:0] rd_data,
	output logic      [7:0] pin_oe,
	output logic      [7:0] pullup_en
);

	////////////////////////////////////////////////////////////////////////
	// per bit: input pins read the pin, output pins read the latch
	assign rd_data = ((pin_in & direction) | (latch & ~direction))
		& DATA_MASK;

	// the latch loads whatever the pin mode, so software can preset a value
	// before turning a pin to output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch <= PPLB_LATCH_RESET;
		end else if (wr_data_en) begin
			latch <= wdata & DATA_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pull_sel <= PPLB_PULL_RESET;
		end else if (wr_pull_en) begin
			pull_sel <= wdata & PULL_MASK;
		end
	end

	// enables are registered so the pads see glitch-free levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_oe    <= PPLB_LATCH_RESET;
			pullup_en <= PPLB_PULL_RESET;
		end else begin
			pin_oe    <= ~direction & DATA_MASK;
			pullup_en <= pull_sel & direction & ~alt_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_latch_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_data_en |=> latch == ($past(wdata) & DATA_MASK))
		else $error("latch did not take the written byte");
	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_data_en |=> $stable(latch))
		else $error("latch changed without a write");
	// the edge that releases reset still loads reset values into the
	// enables, so each check starts one edge later
	a_pull_gate: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> pullup_en == ($past(pull_sel) & $past(direction)
			& ~$past(alt_out)))
		else $error("pull-up enable does not follow select and mode");
	a_pull_off_out: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> (pullup_en & ~$past(direction)) == 8'h00)
		else $error("pull-up on for an output pin");
	a_oe_follow: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> pin_oe == (~$past(direction) & DATA_MASK))
		else $error("output enable does not follow direction");
	a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
		((latch & ~DATA_MASK) == 8'h00) && ((pull_sel & ~PULL_MASK) == 8'h00))
		else $error("unimplemented bit set");

endmodule

/* File: pplb_top.sv */
// apb slave for the port latches, pull-select registers and port 2 input.
// assumes pin inputs are synchronous to pclk and direction and alternate
// output bits come from the port mode logic outside this block.
`timescale 1ns/1ps

module pplb_top
	import pplb_pkg::*;
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [PPLB_AW-1:0]            paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [PPLB_NSLOT-1:0][7:0]    pin_direction_bit,
	input  wire logic [PPLB_NSLOT-1:0][7:0]    alt_out_active,
	input  wire logic [PPLB_NSLOT-1:0][7:0]    pin_in,
	input  wire logic [7:0]                    port2_input_level,
	output wire logic [PPLB_NSLOT-1:0][7:0]    pin_out,
	output wire logic [PPLB_NSLOT-1:0][7:0]    pin_oe,
	output wire logic [PPLB_NSLOT-1:0][7:0]    pullup_en
);

	////////////////////////////////////////////////////////////////////////
	// decode: the access phase takes two cycles, pready comes from a flop
	wire logic [15:0] reg_idx     = paddr[PPLB_AW-1:2];
	wire logic        acc_first   = psel & penable & ~pready;
	wire logic        acc_done    = psel & penable & pready;
	// only the low byte lane carries register data
	wire logic        wr_commit   = acc_done & pwrite & pstrb[0];
	wire logic        p2_hit      = reg_idx == PPLB_IDX_PORT2;

	wire logic [PPLB_NSLOT-1:0]      data_hit;
	wire logic [PPLB_NSLOT-1:0]      pull_hit;
	wire logic [PPLB_NSLOT-1:0][7:0] bank_rd;
	wire logic [PPLB_NSLOT-1:0][7:0] bank_pull;
	wire logic [PPLB_NSLOT:0][7:0]   rd_chain;

	assign rd_chain[0] = p2_hit ? port2_input_level : 8'h00;

	genvar i;
	generate
		for (i = 0; i < PPLB_NSLOT; i++) begin : g_slot
			assign data_hit[i] = reg_idx == PPLB_DATA_IDX[i];
			assign pull_hit[i] = PPLB_PULL_VALID[i]
				& (reg_idx == PPLB_PULL_IDX[i]);
			assign rd_chain[i+1] = rd_chain[i]
				| (data_hit[i] ? bank_rd[i] : 8'h00)
				| (pull_hit[i] ? bank_pull[i] : 8'h00);

			pplb_port_bank #(
				.DATA_MASK (PPLB_DATA_MASK[i]),
				.PULL_MASK (PPLB_PULL_MASK[i])
			) u_bank (
				.pclk       (pclk),
				.presetn    (presetn),
				.wr_data_en (wr_commit & data_hit[i]),
				.wr_pull_en (wr_commit & pull_hit[i]),
				.wdata      (pwdata[7:0]),
				.direction  (pin_direction_bit[i]),
				.alt_out    (alt_out_active[i]),
				.pin_in     (pin_in[i]),
				.latch      (pin_out[i]),
				.pull_sel   (bank_pull[i]),
				.rd_data    (bank_rd[i]),
				.pin_oe     (pin_oe[i]),
				.pullup_en  (pullup_en[i])
			);
		end
	endgenerate

	wire logic        any_hit    = p2_hit | (|data_hit) | (|pull_hit);
	wire logic [31:0] next_rdata = {PPLB_RDATA_PAD, rd_chain[PPLB_NSLOT]};

	////////////////////////////////////////////////////////////////////////
	// read data is captured in the first access cycle, so it stands stable
	// while pready is high; writes to the read-only port 2 are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= PPLB_RDATA_RESET;
		end else begin
			pready  <= acc_first;
			pslverr <= acc_first & ~any_hit;
			if (acc_first) begin
				prdata <= pwrite ? PPLB_RDATA_RESET : next_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		acc_first |=> pready ##1 !pready)
		else $error("pready is not a one-cycle answer");
	a_read_value: assert property (@(posedge pclk) disable iff (!presetn)
		(acc_first && !pwrite && data_hit[0])
		|=> prdata[7:0] == $past(bank_rd[0]))
		else $error("port 0 read data wrong");
	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		(acc_first && !any_hit)
		|=> pslverr && (prdata == PPLB_RDATA_RESET))
		else $error("unmapped access not flagged");
	a_strb_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(acc_done && pwrite && !pstrb[0]) |=> $stable(pin_out))
		else $error("latch written without a low byte strobe");
	a_p2_read: assert property (@(posedge pclk) disable iff (!presetn)
		(acc_first && !pwrite && p2_hit)
		|=> prdata == {PPLB_RDATA_PAD, $past(port2_input_level)})
		else $error("port 2 read does not return the pin levels");

endmodule

/* File: tb_top.sv */
// register-level bench for the port latch and pull-up bank over apb.
// assumes one pin model stands on all slots; pstrb selects byte 0 except
// in the strobe test.
`timescale 1ns/1ps

module tb_top
	import pplb_pkg::*;
;
	logic                       pclk, presetn, psel, penable, pwrite;
	logic [PPLB_AW-1:0]         paddr;
	logic [31:0]                pwdata, prdata, rd;
	logic [3:0]                 pstrb;
	logic                       pready, pslverr, err;
	logic [7:0]                 p2;
	logic [PPLB_NSLOT-1:0][7:0] dir, alt, ext, ext_en;
	wire  [PPLB_NSLOT-1:0][7:0] pin_in, pin_out, pin_oe, pullup_en;
	int                         fail_count = 0;
	int                         check_count = 0;
	int                         i;

	pplb_top pplb_top_inst(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr,
		.pin_direction_bit(dir), .alt_out_active(alt), .pin_in,
		.port2_input_level(p2), .pin_out, .pin_oe, .pullup_en);
	pplb_pin_model pplb_pin_model_inst(.pclk, .pin_out, .pin_oe, .pullup_en,
		.ext_drive(ext), .ext_en, .pin_in);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// the slave answers after a wait; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [15:0] idx,
		input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		tally_and_finish;
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'h1;
		{dir, alt, ext, ext_en} = '0;
		p2 = 8'ha5;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < PPLB_NSLOT; i++) begin
			apb(1'b0, PPLB_DATA_IDX[i], 8'h00);
			chk(rd, 80'h0);
			if (PPLB_PULL_VALID[i]) begin
				apb(1'b0, PPLB_PULL_IDX[i], 8'h00);
				chk(rd, 80'h0);
			end
		end
		$display("test reset values done");
		for (i = 0; i < PPLB_NSLOT; i++) begin
			apb(1'b1, PPLB_DATA_IDX[i], 8'hff);
			apb(1'b0, PPLB_DATA_IDX[i], 8'h00);
			chk(rd, PPLB_DATA_MASK[i]);
			if (PPLB_PULL_VALID[i]) begin
				apb(1'b1, PPLB_PULL_IDX[i], 8'hff);
				apb(1'b0, PPLB_PULL_IDX[i], 8'h00);
				chk(rd, PPLB_PULL_MASK[i]);
			end
		end
		pstrb <= 4'h0;
		apb(1'b1, PPLB_IDX_PORT1, 8'h00);
		pstrb <= 4'h1;
		apb(1'b0, PPLB_IDX_PORT1, 8'h00);
		chk({err, rd}, {1'b0, 32'h0000_00ff});
		repeat (2) @(posedge pclk);
		chk(pin_out, PPLB_DATA_MASK);
		chk(pin_oe, PPLB_DATA_MASK);
		chk(pullup_en, 80'h0);
		$display("test output mode done");
		dir    <= '1;
		ext_en <= '1;
		ext    <= {PPLB_NSLOT{8'h5a}};
		repeat (2) @(posedge pclk);
		apb(1'b0, PPLB_IDX_PORT0, 8'h00);
		chk(rd, 80'h5a);
		chk(pin_oe, 80'h0);
		chk(pullup_en, PPLB_PULL_MASK);
		apb(1'b1, PPLB_IDX_PORT0, 8'h00);
		apb(1'b0, PPLB_IDX_PORT0, 8'h00);
		chk(rd, 80'h5a);
		ext_en <= '0;
		repeat (2) @(posedge pclk);
		apb(1'b0, PPLB_IDX_PORT0, 8'h00);
		chk(rd, 80'h7f);
		alt <= '1;
		repeat (2) @(posedge pclk);
		chk(pullup_en, 80'h0);
		$display("test input mode done");
		apb(1'b1, PPLB_IDX_PORT2, 8'h00);
		apb(1'b0, PPLB_IDX_PORT2, 8'h00);
		chk(rd, 80'ha5);
		apb(1'b0, 16'hff08, 8'h00);
		chk({err, rd}, {1'b1, 32'h0000_0000});
		dir <= '0;
		repeat (2) @(posedge pclk);
		apb(1'b0, PPLB_IDX_PORT0, 8'h00);
		chk(rd, 80'h0);
		apb(1'b0, PPLB_IDX_PORT1, 8'h00);
		chk(rd, 80'hff);
		$display("test read-only and latch hold done");
		tally_and_finish;
	end
endmodule
